// file: inc/spi_host_pkg.sv
// Constants, carriers and helpers for the sensor register port master
package spi_host_pkg;

  // Access word layout
  localparam int ADDR_W     = 9;
  localparam int DIR_W      = 1;
  localparam int DATA_W     = 16;
  localparam int FRAME_BITS = ADDR_W + DIR_W + DATA_W;

  // Direction bit values
  localparam logic DIR_WRITE = 1'b1;
  localparam logic DIR_READ  = 1'b0;

  // Idle levels of the link pins
  localparam logic SS_N_IDLE = 1'b1;
  localparam logic SCK_IDLE  = 1'b0;

  // Clock periods in nanoseconds
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCK_PERIOD_NS = 100;

  // Half serial period in system cycles, a least time so rounded up
  localparam int SCK_HALF_RAW = (SCK_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCK_HALF_CYC = (SCK_HALF_RAW < 1) ? 1 : SCK_HALF_RAW;
  localparam int HALF_CNT_W   = 4;
  localparam logic [HALF_CNT_W-1:0] HALF_LAST = HALF_CNT_W'(SCK_HALF_CYC - 1);

  // Link timing in serial clock periods, two half-period ticks each
  localparam int TICKS_PER_PERIOD = 2;
  localparam int TSSSCK_PERIODS   = 1;
  localparam int TSCKSS_PERIODS   = 1;
  localparam int TSPI_PERIODS     = 2;
  localparam int PH_CNT_W         = 3;
  localparam logic [PH_CNT_W-1:0] LEAD_LAST =
    PH_CNT_W'(TSSSCK_PERIODS * TICKS_PER_PERIOD - 1);
  localparam logic [PH_CNT_W-1:0] TAIL_LAST =
    PH_CNT_W'(TSCKSS_PERIODS * TICKS_PER_PERIOD - 1);
  localparam logic [PH_CNT_W-1:0] GAP_LAST  =
    PH_CNT_W'(TSPI_PERIODS * TICKS_PER_PERIOD - 1);
  localparam logic [PH_CNT_W-1:0] PH_ZERO   = 3'h0;

  // Bit positions within a frame, counted from the first bit sent
  localparam int BIT_CNT_W = 5;
  localparam logic [BIT_CNT_W-1:0] BIT_ZERO       = 5'h00;
  localparam logic [BIT_CNT_W-1:0] LAST_BIT       = BIT_CNT_W'(FRAME_BITS - 1);
  localparam logic [BIT_CNT_W-1:0] DATA_FIRST_BIT = BIT_CNT_W'(ADDR_W + DIR_W);

  localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;

  // One register access request
  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } spi_req_type;

  // Result of one completed access
  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] rdata;
  } spi_resp_type;

  // Master sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_LEAD  = 3'b001,
    ST_SHIFT = 3'b010,
    ST_TAIL  = 3'b011,
    ST_GAP   = 3'b100
  } host_state_type;

  // Serial frame: address, direction, data or zeros on a read
  function automatic logic [FRAME_BITS-1:0] build_frame(input spi_req_type req);
    logic [DATA_W-1:0] payload;
    payload = (req.write == DIR_WRITE) ? req.wdata : DATA_ZERO;
    return {req.addr, req.write, payload};
  endfunction : build_frame

  // True on bits where a read returns data on miso
  function automatic logic is_read_data_bit(input logic write,
                                            input logic [BIT_CNT_W-1:0] idx);
    return (write == DIR_READ) && (idx >= DATA_FIRST_BIT);
  endfunction : is_read_data_bit

endpackage : spi_host_pkg

// file: rtl/pin_sync3.sv
// Three-stage synchroniser with agreement filter for one pin input
`timescale 1ns/1ps
module pin_sync3 (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic pin_i,
  output logic      level_o
);

  logic meta_ff;
  logic s2_ff;
  logic s3_ff;

  // Capture chain; first stage feeds only the second
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_ff <= 1'b0;
      s2_ff   <= 1'b0;
      s3_ff   <= 1'b0;
    end else begin
      meta_ff <= pin_i;
      s2_ff   <= meta_ff;
      s3_ff   <= s2_ff;
    end
  end

  // Level follows once second and third stages agree
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level_o <= 1'b0;
    end else if (s2_ff == s3_ff) begin
      level_o <= s3_ff;
    end
  end

endmodule : pin_sync3

// file: rtl/sck_tick_gen.sv
// Divider giving one tick per half serial clock period
`timescale 1ns/1ps
module sck_tick_gen
  import spi_host_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic run_i,
  output logic      tick_o
);

  logic [HALF_CNT_W-1:0] cnt_ff;
  logic                  at_last;

  assign at_last = (cnt_ff == HALF_LAST);

  // Counter restarts whenever the link is idle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= '0;
    end else if (!run_i || at_last) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  // Registered tick pulse
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= run_i && at_last;
    end
  end

endmodule : sck_tick_gen

// file: rtl/sensor_spi_host.sv
// Serial master that reads and writes the image sensor's configuration registers
//
// Notes on behaviour
// RL1: Each access carries a 9-bit register address and 16-bit data word.
// RL2: Slave select goes low to start every access; device answers only then.
// RL3: Address goes out msb first, one serial clock period after select falls.
// RL4: Device samples mosi on sck rise; master changes mosi on sck fall.
// RL5: Bit after the address picks direction: one writes, zero reads.
// RL6: On a write the 16-bit data follows the direction bit, msb first.
// RL7: On a read the device returns register contents on miso, msb first.
// RL8: Master captures miso on the falling sck edge, at most 10 MHz.
// RL9: Device keeps miso high impedance unless returning read data.
// RL10: After the last bit, wait one serial period, then raise select.
// RL11: Device port runs on sck alone, asynchronous to its system clock.
// RL12: Keep sck below one sixth PLL clock or 1/30, 1/24 of LVDS clock.
// RL13: At nominal input clocks, sck never exceeds 10 MHz.
// RL14: Between accesses select stays high at least two serial periods.
// RL15: Device drops a write whose select rises before all data bits arrive.
`timescale 1ns/1ps
module sensor_spi_host
  import spi_host_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // Request side
  input  wire logic         req_valid_i,
  input  wire spi_req_type  req_i,
  output logic              req_ready_o,
  // Completion side
  output logic              resp_valid_o,
  output spi_resp_type      resp_o,
  output logic              busy_o,
  // Sensor link
  output logic              sck_o,
  output logic              ss_n_o,
  output logic              mosi_o,
  input  wire logic         miso_i
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [1:0]            rst_pipe_ff;
  logic                  rst_n;

  host_state_type        state_ff;
  host_state_type        nxt_state;

  logic                  sck_ff;
  logic                  ss_n_ff;
  logic [FRAME_BITS-1:0] shift_ff;
  logic [DATA_W-1:0]     rdata_ff;
  logic [BIT_CNT_W-1:0]  bit_cnt_ff;
  logic [PH_CNT_W-1:0]   ph_cnt_ff;
  spi_req_type           cur_req_ff;
  logic                  req_ready_ff;
  logic                  resp_valid_ff;
  spi_resp_type          resp_ff;
  logic                  busy_ff;

  logic                  tick;
  logic                  run;
  logic                  miso_level;
  logic                  accept;
  logic                  sck_rise;
  logic                  sck_fall;
  logic                  last_bit;
  logic                  ph_lead_done;
  logic                  ph_tail_done;
  logic                  ph_gap_done;

  // ---------------------------------------------------------------
  // Reset release through two flip-flops
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_pipe_ff <= 2'h0;
    end else begin
      rst_pipe_ff <= {rst_pipe_ff[0], 1'b1};
    end
  end

  assign rst_n = rst_pipe_ff[1];

  // ---------------------------------------------------------------
  // Serial clock timebase; half period at 10 MHz or slower
  // ---------------------------------------------------------------
  assign run = (state_ff != ST_IDLE);

  sck_tick_gen u_tick (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .run_i   (run),
    .tick_o  (tick)                                     // RL12
  );

  // ---------------------------------------------------------------
  // Read data pin, from the sensor's clock-free logic
  // ---------------------------------------------------------------
  pin_sync3 u_miso_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .pin_i   (miso_i),
    .level_o (miso_level)
  );

  // ---------------------------------------------------------------
  // Event decode
  // ---------------------------------------------------------------
  assign accept       = req_valid_i && req_ready_ff;
  assign sck_rise     = (state_ff == ST_SHIFT) && tick && (sck_ff == SCK_IDLE);
  assign sck_fall     = (state_ff == ST_SHIFT) && tick && (sck_ff != SCK_IDLE);
  assign last_bit     = (bit_cnt_ff == LAST_BIT);
  assign ph_lead_done = tick && (ph_cnt_ff == LEAD_LAST);
  assign ph_tail_done = tick && (ph_cnt_ff == TAIL_LAST);
  assign ph_gap_done  = tick && (ph_cnt_ff == GAP_LAST);

  // ---------------------------------------------------------------
  // Sequencer next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (accept) begin
          nxt_state = ST_LEAD;                          // RL2
        end
      end
      ST_LEAD: begin
        if (ph_lead_done) begin
          nxt_state = ST_SHIFT;                         // RL3
        end
      end
      ST_SHIFT: begin
        if (sck_fall && last_bit) begin
          nxt_state = ST_TAIL;
        end
      end
      ST_TAIL: begin
        if (ph_tail_done) begin
          nxt_state = ST_GAP;                           // RL10
        end
      end
      ST_GAP: begin
        if (ph_gap_done) begin
          nxt_state = ST_IDLE;                          // RL14
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ---------------------------------------------------------------
  // Phase counter for lead, tail and gap waits, in half periods
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ph_cnt_ff <= PH_ZERO;
    end else if (state_ff != nxt_state) begin
      ph_cnt_ff <= PH_ZERO;                             // Fresh count per phase
    end else if (tick && (state_ff != ST_SHIFT)) begin
      ph_cnt_ff <= ph_cnt_ff + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Bit counter across the whole frame
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_ff <= BIT_ZERO;
    end else if (accept) begin
      bit_cnt_ff <= BIT_ZERO;
    end else if (sck_fall && !last_bit) begin
      bit_cnt_ff <= bit_cnt_ff + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Serial clock: idle low, first rise one period after select
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sck_ff <= SCK_IDLE;
    end else if ((state_ff == ST_LEAD) && ph_lead_done) begin
      sck_ff <= ~SCK_IDLE;                              // RL3
    end else if (sck_rise) begin
      sck_ff <= ~SCK_IDLE;
    end else if (sck_fall) begin
      sck_ff <= SCK_IDLE;
    end
  end

  // ---------------------------------------------------------------
  // Slave select: low for the access, high through the gap
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ss_n_ff <= SS_N_IDLE;
    end else if (accept) begin
      ss_n_ff <= ~SS_N_IDLE;                            // RL2
    end else if ((state_ff == ST_TAIL) && ph_tail_done) begin
      ss_n_ff <= SS_N_IDLE;                             // RL10
    end
  end

  // ---------------------------------------------------------------
  // Output shift register: loaded as select falls, then mosi changes only on falling sck
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      shift_ff <= '0;
    end else if (accept) begin
      shift_ff <= build_frame(req_i);                   // RL1 RL3 RL5 RL6
    end else if (sck_fall) begin
      shift_ff <= {shift_ff[FRAME_BITS-2:0], 1'b0};     // RL4
    end
  end

  // ---------------------------------------------------------------
  // Read data capture on falling sck during the data bits
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= DATA_ZERO;
    end else if (accept) begin
      rdata_ff <= DATA_ZERO;
    end else if (sck_fall && is_read_data_bit(cur_req_ff.write, bit_cnt_ff)) begin
      rdata_ff <= {rdata_ff[DATA_W-2:0], miso_level};   // RL7 RL8
    end
  end

  // ---------------------------------------------------------------
  // Request latch, kept for the completion record
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cur_req_ff <= '0;
    end else if (accept) begin
      cur_req_ff <= req_i;
    end
  end

  // ---------------------------------------------------------------
  // Ready: high only in idle, dropped in the accepting cycle
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      req_ready_ff <= 1'b0;
    end else if (accept) begin
      req_ready_ff <= 1'b0;
    end else begin
      req_ready_ff <= (nxt_state == ST_IDLE);           // RL14
    end
  end

  // ---------------------------------------------------------------
  // Busy flag from acceptance until the gap is over
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= accept || (nxt_state != ST_IDLE);
    end
  end

  // ---------------------------------------------------------------
  // Completion pulse and record when select rises
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      resp_valid_ff <= 1'b0;
    end else begin
      resp_valid_ff <= (state_ff == ST_TAIL) && ph_tail_done;
    end
  end

  // Completion record holds until the next completion
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      resp_ff <= '0;
    end else if ((state_ff == ST_TAIL) && ph_tail_done) begin
      resp_ff.write <= cur_req_ff.write;
      resp_ff.addr  <= cur_req_ff.addr;
      resp_ff.rdata <= rdata_ff;
    end
  end

  // ---------------------------------------------------------------
  // Outputs, each straight from a flip-flop
  // ---------------------------------------------------------------
  assign req_ready_o  = req_ready_ff;
  assign resp_valid_o = resp_valid_ff;
  assign resp_o       = resp_ff;
  assign busy_o       = busy_ff;
  assign sck_o        = sck_ff;                         // RL13
  assign ss_n_o       = ss_n_ff;
  assign mosi_o       = shift_ff[FRAME_BITS-1];         // Msb of frame first

endmodule : sensor_spi_host

// file: tb/sensor_spi_host_monitor.sv
// Link timing checker for the sensor register port master
`timescale 1ns/1ps
module sensor_spi_host_monitor
  import spi_host_pkg::*;
(
  input wire logic         clk_i,
  input wire logic         rst_n_i,
  input wire logic         req_valid_i,
  input wire spi_req_type  req_i,
  input wire logic         req_ready_o,
  input wire logic         resp_valid_o,
  input wire spi_resp_type resp_o,
  input wire logic         busy_o,
  input wire logic         sck_o,
  input wire logic         ss_n_o,
  input wire logic         mosi_o,
  input wire logic         miso_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [4:0]  rise_cnt_ff;
  logic [5:0]  hi_cnt_ff;
  logic        sck_q_ff;
  logic        first_ff;
  spi_req_type req_q_ff;
  logic [25:0] frame;
  // Rises per frame, select high time, accepted request
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sck_q_ff    <= 1'b0;
      rise_cnt_ff <= 5'h00;
      hi_cnt_ff   <= 6'h00;
      first_ff    <= 1'b1;
      req_q_ff    <= '0;
    end else begin
      sck_q_ff    <= sck_o;
      rise_cnt_ff <= ss_n_o ? 5'h00 : rise_cnt_ff + 5'(sck_o && !sck_q_ff);
      hi_cnt_ff   <= !ss_n_o ? 6'h00 : hi_cnt_ff + 6'(hi_cnt_ff != 6'h3f);
      first_ff    <= first_ff && ss_n_o;
      if (req_valid_i && req_ready_o) req_q_ff <= req_i;
    end
  end
  // Bits expected on mosi, zeros after a read flag
  assign frame = {req_q_ff.addr, req_q_ff.write, req_q_ff.write ? req_q_ff.wdata : 16'h0000};
  sequence lead_seq;
    !sck_o [*8] ##1 !sck_o ##1 !sck_o;
  endsequence
  sequence tail_seq;
    !ss_n_o [*8] ##1 !ss_n_o ##1 !ss_n_o;
  endsequence
  idle_clock_a: assert property (ss_n_o |-> !sck_o)
    else $error("sck moves while deselected");
  select_start_a: assert property (req_valid_i && req_ready_o |=> !ss_n_o && busy_o)
    else $error("access did not start with select low");
  lead_time_a: assert property ($fell(ss_n_o) |-> lead_seq ##[1:8] $rose(sck_o))
    else $error("select to first rise wrong");
  tail_time_a: assert property ($fell(sck_o) && rise_cnt_ff == 5'h1a |-> tail_seq ##[1:8] $rose(ss_n_o))
    else $error("last fall to select high wrong");
  mosi_edge_a: assert property ($changed(mosi_o) && !ss_n_o && !$fell(ss_n_o) |-> $fell(sck_o))
    else $error("mosi changed off a falling edge");
  mosi_hold_a: assert property ($rose(sck_o) |-> ($past(mosi_o, 2) == mosi_o) ##1 $stable(mosi_o) [*2])
    else $error("mosi setup or hold broken");
  frame_order_a: assert property ($rose(sck_o) |-> mosi_o == frame[5'h19 - rise_cnt_ff])
    else $error("mosi bit out of order");
  frame_bits_a: assert property ($rose(ss_n_o) |-> rise_cnt_ff == 5'h1a && resp_valid_o)
    else $error("frame not 26 clocks");
  sck_high_a: assert property ($rose(sck_o) |-> sck_o [*5] ##1 !sck_o)
    else $error("sck high time wrong");
  sck_low_a: assert property ($fell(sck_o) && rise_cnt_ff != 5'h1a |-> !sck_o [*5] ##1 sck_o)
    else $error("sck low time wrong");
  gap_time_a: assert property ($fell(ss_n_o) && !first_ff |-> hi_cnt_ff >= 6'h14)
    else $error("select high gap too short");
endmodule : sensor_spi_host_monitor

bind sensor_spi_host sensor_spi_host_monitor chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i), .req_i(req_i),
  .req_ready_o(req_ready_o), .resp_valid_o(resp_valid_o), .resp_o(resp_o),
  .busy_o(busy_o), .sck_o(sck_o), .ss_n_o(ss_n_o), .mosi_o(mosi_o), .miso_i(miso_i)
);

// file: tb/sensor_reg_model.sv
// Behavioural sensor register port answering the master's frames
`timescale 1ns/1ps
module sensor_reg_model #(
  parameter logic [15:0] INIT_XOR = 16'h5a5a // Arbitrary reset pattern
) (
  input  wire logic sck_i,
  input  wire logic ss_n_i,
  input  wire logic mosi_i,
  output logic      miso_o
);
  logic [15:0] regs [512];
  logic [25:0] sh_ff    = 26'h000_0000;
  logic [4:0]  cnt_ff   = 5'h00;
  logic [15:0] out_ff   = 16'h0000;
  logic        drive_ff = 1'b0;
  // Power-up contents
  initial for (int i = 0; i < 512; i++) regs[i] = INIT_XOR ^ 16'(i);
  // Shift in on sck rise, restart while deselected
  always @(posedge sck_i or posedge ss_n_i) begin
    if (ss_n_i) begin
      cnt_ff <= 5'h00;
    end else begin
      sh_ff  <= {sh_ff[24:0], mosi_i};
      cnt_ff <= cnt_ff + 5'h01;
      // Commit only a complete write frame
      if (cnt_ff == 5'h19 && sh_ff[15]) begin
        regs[sh_ff[24:16]] <= {sh_ff[14:0], mosi_i};
      end
    end
  end
  // Read data msb first from the fall after the flag
  always @(negedge sck_i or posedge ss_n_i) begin
    if (ss_n_i) begin
      drive_ff <= 1'b0;
    end else if (cnt_ff == 5'h0a && !sh_ff[0]) begin
      out_ff   <= regs[sh_ff[9:1]];
      drive_ff <= 1'b1;
    end else begin
      drive_ff <= drive_ff && cnt_ff != 5'h1a;
      out_ff   <= {out_ff[14:0], ~out_ff[15]};
    end
  end
  // Released line shows the inverse of the out_ff msb, which keeps shifting
  assign miso_o = drive_ff ? out_ff[15] : ~out_ff[15];
endmodule : sensor_reg_model

// file: tb/sensor_spi_host_bench.sv
// Self-checking bench for the sensor register port master
`timescale 1ns/1ps
module sensor_spi_host_bench
  import spi_host_pkg::*;
;
  localparam logic [15:0] INIT_XOR = 16'ha5c3; // Arbitrary reset pattern
  logic         clk_i       = 1'b0;
  logic         rst_n_i     = 1'b0;
  logic         req_valid_i = 1'b0;
  spi_req_type  req_i       = '0;
  logic         req_ready_o;
  logic         resp_valid_o;
  logic         busy_o;
  logic         sck_o;
  logic         ss_n_o;
  logic         mosi_o;
  logic         miso_i;
  spi_resp_type resp_o;
  logic [31:0]  rng_state   = 32'h0000_7ba8;
  logic [15:0]  shadow [512];
  int           n_mismatch  = 0;
  int           samples_checked = 0;

  // System clock
  always #5 clk_i = ~clk_i;

  sensor_spi_host DUT (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i), .req_i(req_i),
    .req_ready_o(req_ready_o), .resp_valid_o(resp_valid_o), .resp_o(resp_o),
    .busy_o(busy_o), .sck_o(sck_o), .ss_n_o(ss_n_o), .mosi_o(mosi_o), .miso_i(miso_i)
  );
  sensor_reg_model #(.INIT_XOR(INIT_XOR)) device (
    .sck_i(sck_o), .ss_n_i(ss_n_o), .mosi_i(mosi_o), .miso_o(miso_i)
  );

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift

  // Response expected before the shadow is updated
  function automatic logic [25:0] expect_resp(input spi_req_type r);
    return {r.write, r.addr, r.write ? 16'h0000 : shadow[r.addr]};
  endfunction : expect_resp

  task automatic check(input logic [25:0] got, input logic [25:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // One access: hold valid until ready, then await completion
  task automatic access(input spi_req_type r);
    logic [25:0] exp;
    int          t;
    exp = expect_resp(r);
    if (r.write) shadow[r.addr] = r.wdata;
    @(negedge clk_i);
    req_i       = r;
    req_valid_i = 1'b1;
    t = 0;
    while (req_ready_o !== 1'b1 && t < 2000) begin
      @(negedge clk_i);
      t++;
    end
    // A request never taken ends the run as a failure
    if (t >= 2000) begin
      n_mismatch++;
      end_of_test();
    end
    @(negedge clk_i);
    req_valid_i = 1'b0;
    t = 0;
    while (resp_valid_o !== 1'b1 && t < 2000) begin
      @(negedge clk_i);
      t++;
    end
    // A completion that never comes ends the run as a failure
    if (t >= 2000) begin
      n_mismatch++;
      end_of_test();
    end
    check(resp_o, exp);
  endtask : access

  task automatic end_of_test;
    if (n_mismatch == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test

  // Corner accesses, then back-to-back random traffic
  initial begin : main
    spi_req_type r;
    logic [25:0] corner [8];
    corner = '{26'h000_0000, 26'h1ff_0000, 26'h3ff_ffff, 26'h200_0000,
               26'h1ff_0000, 26'h000_0000, 26'h2aa_8001, 26'h0aa_0000};
    for (int i = 0; i < 512; i++) shadow[i] = INIT_XOR ^ 16'(i);
    repeat (10) @(negedge clk_i);
    rst_n_i = 1'b1;
    check({24'h00_0000, ss_n_o, sck_o}, 26'h000_0002);
    foreach (corner[k]) access(corner[k]);
    repeat (24) begin
      rng_state = xorshift(rng_state);
      r = spi_req_type'(rng_state[25:0]);
      if (rng_state[30]) r.addr[8:3] = 6'h3f;
      access(r);
    end
    end_of_test();
  end

  // Cuts a hang short
  initial begin : watchdog
    #300000;
    n_mismatch++;
    end_of_test();
  end
endmodule : sensor_spi_host_bench
